// File: include/gpib_pkg.sv
// Shared constants and types for the instrument bus device interface.
`default_nettype none
package gpib_pkg;
	// Clock and handshake timing.
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_W = 7;
	localparam logic [SETTLE_W-1:0] SETTLE_CYCLES =
		SETTLE_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Address field on bits 4 to 0; command groups on bits 6 to 5 or 6 to 4 of a command byte.
	localparam logic [4:0] MAX_ADDR = 5'h1E;
	localparam logic [4:0] UNADDR = 5'h1F;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [2:0] GRP_ADDRESSED = 3'h0;
	localparam logic [2:0] GRP_UNIVERSAL = 3'h1;
	// Command bytes.
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	// Status byte layout.
	localparam int RQS_BIT = 6;
	// Values after reset.
	localparam logic POWERUP_REQ_RESET = 1'b1;
	typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_HOLD} accept_state_t;
	typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_WAIT} source_state_t;
endpackage
`default_nettype wire

// File: src/bus_source.sv
// Three-wire source handshake that puts one byte at a time on the bus.
`timescale 1ns/10ps
`default_nettype none
module bus_source
	import gpib_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte to send
	input wire logic enable,
	input wire logic valid,
	input wire logic [7:0] data,
	input wire logic last,
	output logic done,
	// Bus side, wire levels active low
	input wire logic nrfd_n_i,
	input wire logic ndac_n_i,
	output logic [7:0] dio_oe,
	output logic dav_oe,
	output logic eoi_oe
);
	source_state_t state, next_state;
	logic [SETTLE_W-1:0] cnt, next_cnt;
	logic [7:0] next_dio_oe;
	logic next_dav_oe, next_eoi_oe, next_done;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_dio_oe = dio_oe;
		next_dav_oe = dav_oe;
		next_eoi_oe = eoi_oe;
		next_done = 1'b0;
		case (state)
			SRC_IDLE:
			begin
				// The done gap lets the user drop valid before a retake.
				if (enable && valid && !done && nrfd_n_i && !ndac_n_i)
				begin
					next_dio_oe = data;
					next_eoi_oe = last;
					next_cnt = SETTLE_CYCLES - SETTLE_W'(1);
					next_state = SRC_SETTLE;
				end
			end
			SRC_SETTLE:
			begin
				if (cnt == '0)
				begin
					next_dav_oe = 1'b1;
					next_state = SRC_WAIT;
				end
				else
				begin
					next_cnt = cnt - SETTLE_W'(1);
				end
			end
			default:
			begin
				if (ndac_n_i)
				begin
					next_dav_oe = 1'b0;
					next_dio_oe = 8'h00;
					next_eoi_oe = 1'b0;
					next_done = 1'b1;
					next_state = SRC_IDLE;
				end
			end
		endcase
		// Losing the talk role drops the bus at once, mid-byte or not.
		if (!enable)
		begin
			next_state = SRC_IDLE;
			next_dio_oe = 8'h00;
			next_dav_oe = 1'b0;
			next_eoi_oe = 1'b0;
			next_done = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SRC_IDLE;
			cnt <= '0;
			dio_oe <= 8'h00;
			dav_oe <= 1'b0;
			eoi_oe <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			dio_oe <= next_dio_oe;
			dav_oe <= next_dav_oe;
			eoi_oe <= next_eoi_oe;
			done <= next_done;
		end
	end
endmodule // bus_source
`default_nettype wire

// File: src/gpib_device_if.sv
// Instrument-side interface to the general purpose instrument bus.
//
// Notes on behaviour
// - Own address 0..30 selects talker or listener.
// - Attention off: bytes are device data.
// - Attention on: data byte is interface command.
// - Universal always; addressed commands only when listener.
// - Uni-line messages use five management lines.
// - Errors or completion raise service request; polled.
// - Unlisten idles listener; untalk idles talker.
// - Interface clear idles roles, flushes buffers.
// - Serial poll enable sends status; disable restores.
// - Device clear flushes, drops non-power-up request.
`timescale 1ns/10ps
`default_nettype none
module gpib_device_if
	import gpib_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Address select switches
	input wire logic [4:0] MY_ADDR,
	// Bus lines, wire levels active low
	input wire logic [7:0] DIO_N_I,
	output logic [7:0] DIO_N_O,
	output logic [7:0] DIO_N_OE,
	input wire logic DAV_N_I,
	output logic DAV_N_O,
	output logic DAV_N_OE,
	input wire logic NRFD_N_I,
	output logic NRFD_N_O,
	output logic NRFD_N_OE,
	input wire logic NDAC_N_I,
	output logic NDAC_N_O,
	output logic NDAC_N_OE,
	input wire logic EOI_N_I,
	output logic EOI_N_O,
	output logic EOI_N_OE,
	output logic SRQ_N_O,
	output logic SRQ_N_OE,
	input wire logic ATN_N_I,
	input wire logic IFC_N_I,
	input wire logic REN_N_I,
	// Received device data
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic RX_END,
	// Data to send
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_END,
	output logic TX_ACK,
	// Instrument status and events
	input wire logic [5:0] STATUS,
	input wire logic SVC_EVENT,
	output logic TALKER,
	output logic LISTENER,
	output logic SERIAL_POLL,
	output logic REMOTE,
	output logic LOCKOUT,
	output logic SRQ_PENDING,
	output logic DEV_CLEAR,
	output logic IF_CLEAR
);
	accept_state_t ah, next_ah;
	logic atn, ifc, ren, dav, eoi, take, addr_ok, src_enable, src_done;
	logic [7:0] cmd, poll_byte, src_data;
	logic [7:0] next_rx_data;
	logic next_rx_valid, next_rx_end, next_talker, next_listener;
	logic next_spoll, next_remote, next_lockout, next_dev_clear;
	logic next_if_clear, srq_pend, next_srq_pend, pwr_pend, next_pwr_pend;
	logic nrfd_oe, next_nrfd_oe, ndac_oe, next_ndac_oe, next_srq_oe, pull;
	assign atn = ~ATN_N_I;
	assign ifc = ~IFC_N_I;
	assign ren = ~REN_N_I;
	assign dav = ~DAV_N_I;
	assign eoi = ~EOI_N_I;
	assign cmd = ~DIO_N_I;
	assign addr_ok = (MY_ADDR <= MAX_ADDR);
	////////////////////////////////////////////////////////////////////////
	// Acceptor handshake and command decoding.
	always_comb
	begin
		next_ah = ah;
		take = 1'b0;
		next_rx_data = RX_DATA;
		next_rx_valid = 1'b0;
		next_rx_end = RX_END;
		next_talker = TALKER;
		next_listener = LISTENER;
		next_spoll = SERIAL_POLL;
		next_remote = REMOTE;
		next_lockout = LOCKOUT;
		next_dev_clear = 1'b0;
		next_if_clear = 1'b0;
		next_srq_pend = srq_pend;
		next_pwr_pend = pwr_pend;
		// Every device joins the handshake while attention is on.
		case (ah)
			AH_IDLE:
			begin
				if (atn || LISTENER)
				begin
					next_ah = AH_READY;
				end
			end
			AH_READY:
			begin
				if (!(atn || LISTENER))
				begin
					next_ah = AH_IDLE;
				end
				else if (dav)
				begin
					take = 1'b1;
					next_ah = AH_HOLD;
				end
			end
			default:
			begin
				if (!dav)
				begin
					next_ah = (atn || LISTENER) ? AH_READY : AH_IDLE;
				end
			end
		endcase
		if (take && atn)
		begin
			if (cmd[6:5] == GRP_LISTEN)
			begin
				if (cmd[4:0] == UNADDR)
				begin
					next_listener = 1'b0;
				end
				else if (addr_ok && cmd[4:0] == MY_ADDR)
				begin
					next_listener = 1'b1;
					next_talker = 1'b0;
					next_remote = REMOTE | ren;
				end
			end
			else if (cmd[6:5] == GRP_TALK)
			begin
				// Another talk address takes the talk role from us.
				next_talker = addr_ok && cmd[4:0] == MY_ADDR;
				if (addr_ok && cmd[4:0] == MY_ADDR)
				begin
					next_listener = 1'b0;
				end
			end
			else if (cmd[6:4] == GRP_UNIVERSAL)
			begin
				if (cmd[6:0] == CMD_DCL[6:0])
				begin
					next_dev_clear = 1'b1;
				end
				else if (cmd[6:0] == CMD_LLO[6:0])
				begin
					next_lockout = 1'b1;
				end
				else if (cmd[6:0] == CMD_SPE[6:0])
				begin
					next_spoll = 1'b1;
				end
				else if (cmd[6:0] == CMD_SPD[6:0])
				begin
					next_spoll = 1'b0;
				end
			end
			else if (cmd[6:4] == GRP_ADDRESSED && LISTENER)
			begin
				if (cmd[6:0] == CMD_SDC[6:0])
				begin
					next_dev_clear = 1'b1;
				end
				else if (cmd[6:0] == CMD_GTL[6:0])
				begin
					next_remote = 1'b0;
				end
			end
		end
		else if (take && LISTENER)
		begin
			next_rx_data = cmd;
			next_rx_valid = 1'b1;
			next_rx_end = eoi;
		end
		if (next_dev_clear)
		begin
			next_srq_pend = 1'b0;
		end
		// A poll answered clears the request; a new event still wins.
		if (src_done && SERIAL_POLL)
		begin
			next_srq_pend = 1'b0;
			next_pwr_pend = 1'b0;
		end
		if (SVC_EVENT)
		begin
			next_srq_pend = 1'b1;
		end
		if (!ren)
		begin
			next_remote = 1'b0;
			next_lockout = 1'b0;
		end
		// Interface clear touches the interface only, never settings.
		if (ifc)
		begin
			next_talker = 1'b0;
			next_listener = 1'b0;
			next_spoll = 1'b0;
			next_rx_valid = 1'b0;
			next_if_clear = 1'b1;
			next_ah = AH_IDLE;
		end
		next_nrfd_oe = (next_ah == AH_HOLD);
		next_ndac_oe = (next_ah == AH_READY);
		next_srq_oe = next_srq_pend | next_pwr_pend;
	end
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ah <= AH_IDLE;
			RX_DATA <= 8'h00;
			RX_VALID <= 1'b0;
			RX_END <= 1'b0;
			TALKER <= 1'b0;
			LISTENER <= 1'b0;
			SERIAL_POLL <= 1'b0;
			REMOTE <= 1'b0;
			LOCKOUT <= 1'b0;
			DEV_CLEAR <= 1'b0;
			IF_CLEAR <= 1'b0;
			srq_pend <= 1'b0;
			pwr_pend <= POWERUP_REQ_RESET;
			nrfd_oe <= 1'b0;
			ndac_oe <= 1'b0;
			SRQ_N_OE <= POWERUP_REQ_RESET;
			SRQ_PENDING <= POWERUP_REQ_RESET;
			pull <= 1'b0;
		end
		else
		begin
			ah <= next_ah;
			RX_DATA <= next_rx_data;
			RX_VALID <= next_rx_valid;
			RX_END <= next_rx_end;
			TALKER <= next_talker;
			LISTENER <= next_listener;
			SERIAL_POLL <= next_spoll;
			REMOTE <= next_remote;
			LOCKOUT <= next_lockout;
			DEV_CLEAR <= next_dev_clear;
			IF_CLEAR <= next_if_clear;
			srq_pend <= next_srq_pend;
			pwr_pend <= next_pwr_pend;
			nrfd_oe <= next_nrfd_oe;
			ndac_oe <= next_ndac_oe;
			SRQ_N_OE <= next_srq_oe;
			SRQ_PENDING <= next_srq_oe;
			pull <= 1'b0;
		end
	end
	assign NRFD_N_OE = nrfd_oe;
	assign NDAC_N_OE = ndac_oe;
	// Open-drain lines only ever pull low.
	assign DIO_N_O = {8{pull}};
	assign DAV_N_O = pull;
	assign NRFD_N_O = pull;
	assign NDAC_N_O = pull;
	assign EOI_N_O = pull;
	assign SRQ_N_O = pull;
	////////////////////////////////////////////////////////////////////////
	// Talker: status byte while polled, else user data.
	assign poll_byte = {1'b0, SRQ_PENDING, STATUS};
	assign src_data = SERIAL_POLL ? poll_byte : TX_DATA;
	assign src_enable = TALKER && !atn && !ifc;
	assign TX_ACK = src_done && !SERIAL_POLL;
	bus_source u_source (
		.clk(MCLK),
		.rst_n(RST_N),
		.enable(src_enable),
		.valid(SERIAL_POLL | TX_VALID),
		.data(src_data),
		.last(!SERIAL_POLL && TX_END),
		.done(src_done),
		.nrfd_n_i(NRFD_N_I),
		.ndac_n_i(NDAC_N_I),
		.dio_oe(DIO_N_OE),
		.dav_oe(DAV_N_OE),
		.eoi_oe(EOI_N_OE)
	);
endmodule // gpib_device_if
`default_nettype wire

// File: testbench/gpib_device_if_asserts.sv
// Concurrent checks on the instrument bus device interface ports.
`timescale 1ns/10ps
`default_nettype none
module gpib_device_if_asserts
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Bus side
	input wire logic [4:0] MY_ADDR,
	input wire logic [7:0] DIO_N_I,
	input wire logic DAV_N_I,
	input wire logic NRFD_N_OE,
	input wire logic NDAC_N_OE,
	input wire logic ATN_N_I,
	input wire logic IFC_N_I,
	input wire logic SRQ_N_OE,
	// User side
	input wire logic RX_VALID,
	input wire logic SVC_EVENT,
	input wire logic TALKER,
	input wire logic LISTENER,
	input wire logic SERIAL_POLL,
	input wire logic SRQ_PENDING,
	input wire logic DEV_CLEAR,
	input wire logic IF_CLEAR
);
	// A byte counts as taken only in the ready state with valid low.
	logic taken;
	logic data_take;
	assign taken = !DAV_N_I && NDAC_N_OE && !NRFD_N_OE && IFC_N_I;
	assign data_take = taken && ATN_N_I && LISTENER;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence cmd_taken;
		taken && !ATN_N_I;
	endsequence
	sequence cmd_is(logic [6:0] c);
		cmd_taken ##0 (~DIO_N_I[6:0] == c);
	endsequence
	a_rx_source:
		assert property (RX_VALID |-> $past(data_take))
		else $error("data byte taken while not listening");
	a_cmd_accept:
		assert property (cmd_taken |=> NRFD_N_OE && !NDAC_N_OE)
		else $error("command byte not accepted");
	a_my_listen:
		assert property (cmd_is({2'h1, MY_ADDR}) ##0 MY_ADDR <= 5'h1E
		|=> LISTENER) else $error("own listen address missed");
	a_my_talk:
		assert property (cmd_is({2'h2, MY_ADDR}) ##0 MY_ADDR <= 5'h1E
		|=> TALKER && !LISTENER) else $error("own talk address missed");
	a_unlisten_idle:
		assert property (cmd_is(7'h3F) |=> !LISTENER)
		else $error("listener kept after unlisten");
	a_untalk_idle:
		assert property (cmd_is(7'h5F) |=> !TALKER)
		else $error("talker kept after untalk");
	a_dev_clear:
		assert property (cmd_is(7'h14) |=> DEV_CLEAR)
		else $error("device clear not signalled");
	a_poll_on:
		assert property (cmd_is(7'h18) |=> SERIAL_POLL)
		else $error("serial poll not entered");
	a_ifc_idle:
		assert property (!IFC_N_I |=> !TALKER && !LISTENER && IF_CLEAR)
		else $error("interface clear ignored");
	a_srq_raise:
		assert property (SVC_EVENT |=> SRQ_N_OE && SRQ_PENDING)
		else $error("service request not raised");
	a_sdc_ignored:
		assert property (cmd_is(7'h04) ##0 !LISTENER |=> !DEV_CLEAR)
		else $error("device clear taken while not listening");
	a_poll_off:
		assert property (cmd_is(7'h19) |=> !SERIAL_POLL)
		else $error("serial poll not left");
endmodule // gpib_device_if_asserts
bind gpib_device_if gpib_device_if_asserts gpib_device_if_asserts_i (
	.MCLK(MCLK),
	.RST_N(RST_N),
	.MY_ADDR(MY_ADDR),
	.DIO_N_I(DIO_N_I),
	.DAV_N_I(DAV_N_I),
	.NRFD_N_OE(NRFD_N_OE),
	.NDAC_N_OE(NDAC_N_OE),
	.ATN_N_I(ATN_N_I),
	.IFC_N_I(IFC_N_I),
	.SRQ_N_OE(SRQ_N_OE),
	.RX_VALID(RX_VALID),
	.SVC_EVENT(SVC_EVENT),
	.TALKER(TALKER),
	.LISTENER(LISTENER),
	.SERIAL_POLL(SERIAL_POLL),
	.SRQ_PENDING(SRQ_PENDING),
	.DEV_CLEAR(DEV_CLEAR),
	.IF_CLEAR(IF_CLEAR)
);
`default_nettype wire

// File: testbench/ctlr.sv
// Bus controller model: sends commands and data, reads talker bytes.
`timescale 1ns/10ps
`default_nettype none
module ctlr
(
	// Clock
	input wire logic clk,
	// Wire levels, low asserted
	input wire logic [7:0] dio_n,
	input wire logic dav_n,
	input wire logic nrfd_n,
	input wire logic ndac_n,
	input wire logic eoi_n,
	// Lines this side pulls low
	output logic [7:0] dio,
	output logic dav,
	output logic nrfd,
	output logic ndac,
	output logic atn,
	output logic ifc,
	output logic ren,
	output logic eoi
);
	initial {dio, dav, nrfd, ndac, atn, ifc, ren, eoi} = '0;
	// Attention is held through the byte so a command never leaks as data.
	task automatic put(input logic a, input logic [7:0] b, output bit ok);
		int n;
		n = 0;
		@(negedge clk);
		atn = a;
		{nrfd, ndac} = 2'h0;
		dio = b;
		do @(negedge clk); while (!nrfd_n && ++n < 300);
		dav = 1'h1;
		do @(negedge clk); while (!ndac_n && ++n < 300);
		@(negedge clk);
		{dav, dio} = '0;
		ok = n < 300;
	endtask
	// Not-ready stays up afterwards, so a repeating talker waits for us.
	task automatic get(output logic [7:0] b, output logic e, output bit ok);
		int n;
		n = 0;
		@(negedge clk);
		atn = 1'h0;
		{nrfd, ndac} = 2'h1;
		do @(negedge clk); while (dav_n && ++n < 400);
		b = ~dio_n;
		e = !eoi_n;
		@(negedge clk);
		{nrfd, ndac} = 2'h2;
		do @(negedge clk); while (!dav_n && ++n < 400);
		@(negedge clk);
		ndac = 1'h1;
		ok = n < 400;
	endtask
endmodule // ctlr
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the instrument bus device interface.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, rst_n, svc, tx_v, tx_e, dav, nrfd, ndac, atn, ifc, ren, e;
	logic dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, rx_v, ack, tk, ls;
	logic sp, rem, lko, srqp, dclr, iclr, ceoi, rxe;
	logic [4:0] adr;
	logic [5:0] st;
	logic [7:0] tx_d, rx_d, dio_oe, dio, b, g, nrx, ndc, nack;
	bit ok;
	int mismatches, tests_run;
	wire logic [7:0] dio_n = ~(dio_oe | dio);
	wire logic dav_n = ~(dav_oe | dav);
	wire logic nrfd_n = ~(nrfd_oe | nrfd);
	wire logic ndac_n = ~(ndac_oe | ndac);
	wire logic eoi_n = ~(eoi_oe | ceoi);
	gpib_device_if gpib_device_if_i (.MCLK(clk), .RST_N(rst_n),
		.MY_ADDR(adr), .DIO_N_I(dio_n), .DIO_N_O(), .DIO_N_OE(dio_oe),
		.DAV_N_I(dav_n), .DAV_N_O(), .DAV_N_OE(dav_oe), .NRFD_N_I(nrfd_n),
		.NRFD_N_O(), .NRFD_N_OE(nrfd_oe), .NDAC_N_I(ndac_n), .NDAC_N_O(),
		.NDAC_N_OE(ndac_oe), .EOI_N_I(eoi_n), .EOI_N_O(),
		.EOI_N_OE(eoi_oe), .SRQ_N_O(), .SRQ_N_OE(srq_oe), .ATN_N_I(~atn),
		.IFC_N_I(~ifc), .REN_N_I(~ren), .RX_DATA(rx_d), .RX_VALID(rx_v),
		.RX_END(rxe), .TX_DATA(tx_d), .TX_VALID(tx_v), .TX_END(tx_e),
		.TX_ACK(ack), .STATUS(st), .SVC_EVENT(svc), .TALKER(tk),
		.LISTENER(ls), .SERIAL_POLL(sp), .REMOTE(rem), .LOCKOUT(lko),
		.SRQ_PENDING(srqp), .DEV_CLEAR(dclr), .IF_CLEAR(iclr));
	ctlr ctlr_i (.clk(clk), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
		.ndac_n(ndac_n), .eoi_n(eoi_n), .dio(dio), .dav(dav), .nrfd(nrfd),
		.ndac(ndac), .atn(atn), .ifc(ifc), .ren(ren), .eoi(ceoi));
	// Pulses are counted here so no one-cycle output is missed.
	always @(posedge clk)
	begin
		nrx <= nrx + 8'(rx_v);
		ndc <= ndc + 8'(dclr);
		nack <= nack + 8'(ack);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic need;
		chk(8'(ok), 8'h01);
		if (!ok)
			wrap_up();
	endtask
	task automatic cmd(input logic [7:0] c);
		ctlr_i.put(1'h1, c, ok);
		need();
	endtask
	task automatic t_listen;
		ctlr_i.ren = 1'h1;
		cmd({3'h1, adr});
		chk(ls, 1'h1);
		chk(rem, 1'h1);
		b = nrx;
		ctlr_i.eoi = 1'h1;
		ctlr_i.put(1'h0, 8'hA5, ok);
		ctlr_i.eoi = 1'h0;
		need();
		chk(rx_d, 8'hA5);
		chk(8'(rxe), 8'h01);
		chk(nrx, b + 8'h01);
		cmd({3'h1, adr - 5'h01});
		chk(ls, 1'h1);
		cmd(8'h11);
		chk(lko, 1'h1);
		cmd(8'h01);
		chk(rem, 1'h0);
		cmd(8'h3F);
		chk(ls, 1'h0);
		b = nrx;
		ctlr_i.put(1'h0, 8'h5A, ok);
		need();
		chk(nrx, b);
		$display("listen test done");
	endtask
	task automatic t_talk;
		cmd({3'h2, adr});
		chk(tk, 1'h1);
		for (int i = 0; i < 2; i++)
		begin
			b = nack;
			tx_d = 8'hC3 ^ 8'(i);
			tx_e = i[0];
			tx_v = 1'h1;
			ctlr_i.get(g, e, ok);
			tx_v = 1'h0;
			need();
			chk(g, 8'hC3 ^ 8'(i));
			chk(e, i[0]);
			chk(nack, b + 8'h01);
		end
		$display("talk test done");
	endtask
	task automatic t_poll;
		svc = 1'h1;
		@(negedge clk);
		svc = 1'h0;
		chk(srq_oe, 1'h1);
		cmd(8'h18);
		chk(sp, 1'h1);
		ctlr_i.get(g, e, ok);
		need();
		chk(g, {2'h1, st});
		chk(srqp, 1'h0);
		cmd(8'h19);
		chk(sp, 1'h0);
		cmd(8'h5F);
		chk(tk, 1'h0);
		$display("poll test done");
	endtask
	task automatic t_clear;
		cmd({3'h1, adr});
		svc = 1'h1;
		@(negedge clk);
		svc = 1'h0;
		chk(srqp, 1'h1);
		b = ndc;
		cmd(8'h14);
		chk(srqp, 1'h0);
		cmd(8'h04);
		chk(ndc, b + 8'h02);
		cmd(8'h3F);
		cmd(8'h04);
		chk(ndc, b + 8'h02);
		cmd({3'h1, adr});
		cmd({3'h2, adr});
		chk(ls, 1'h0);
		ctlr_i.ifc = 1'h1;
		repeat (3) @(negedge clk);
		chk(iclr, 1'h1);
		ctlr_i.ifc = 1'h0;
		chk(tk, 1'h0);
		$display("clear test done");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		{rst_n, svc, tx_v, tx_e, tx_d, nrx, ndc, nack} = '0;
		adr = 5'h1E;
		st = 6'h2B;
		repeat (10) @(negedge clk);
		rst_n = 1'h1;
		chk(srq_oe, 1'h1);
		t_listen();
		t_talk();
		t_poll();
		t_clear();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
